// ---- logic/maint_test_sequencer.sv ----
// maintenance mode test sequencer top
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`include "maint_seq_map.svh"
`timescale 1ns/1ps
module maint_test_sequencer (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] switch_bank_i,
    input wire logic online_i,
    input wire logic [3:0] drive_status_i,
    output logic [6:0] drive_cmd_o,
    output logic maint_active_o,
    output logic irq_o
);
    typedef struct packed {
        logic seen_rst;
        logic enabled;
        logic online;
        maint_seq_pkg::seq_state_t state;
        maint_seq_pkg::maintenance_config_switch_bank_t cfg;
        maint_seq_pkg::drive_cmd_t cmd;
        logic [2:0] events;
        maint_seq_pkg::drive_status_t ds_q;
        logic [2:0] settle;
    } top_state_t;
    top_state_t st_q;
    top_state_t st_d;
    logic [7:0] sw_s;
    logic online_s;
    logic [3:0] ds_s;
    maint_seq_pkg::maintenance_config_switch_bank_t sw;
    maint_seq_pkg::drive_status_t ds;
    logic go;
    maint_seq_pkg::drive_status_t ev;
    logic on_rise;
    logic is_read;
    logic no_retry_op;
    logic ignore_cfg;
    logic err;
    logic [7:0] stat;

    pin_sync #(.W(13)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i({switch_bank_i, online_i, drive_status_i}),
        .sync_o({sw_s, online_s, ds_s})
    );

    assign sw = sw_s;
    assign ds = ds_s;
    assign stat = {st_q.enabled, st_q.online, 1'b0, st_q.state, st_q.cmd.halt, go};

    wb_regs u_regs (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .status_i(stat),
        .events_i(st_q.events),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .go_o(go),
        .irq_o(irq_o)
    );

    always_comb
    begin
        st_d = st_q;
        st_d.events = 3'h0;
        st_d.cmd.start = 1'b0;
        st_d.cmd.reposition = 1'b0;
        st_d.online = online_s;
        on_rise = online_s && !st_q.online;
        // drive status acts on its rising edge only, once per event
        ev = ds & ~st_q.ds_q;
        st_d.ds_q = ds;
        // sixteen binary-coded operations
        is_read = (st_q.cfg.op_select == `OP_READ_A) || (st_q.cfg.op_select == `OP_READ_B)
            || (st_q.cfg.op_select == `OP_READ_R)
            || (st_q.cfg.op_select == `OP_READ_REV);
        no_retry_op = (st_q.cfg.op_select == `OP_GAP) || (st_q.cfg.op_select == `OP_FSF)
            || (st_q.cfg.op_select == `OP_BSF);
        ignore_cfg = st_q.cfg.op_select == `OP_FRPI;
        // reads ignore single-track errors
        err = ev.multiple_track_error || ev.runaway
            || (ev.single_track_error && !is_read);
        if (!st_q.seen_rst)
        begin
            // switches are trusted once the synchroniser has filled
            if (st_q.settle != `SYNC_SETTLE)
            begin
                st_d.settle = st_q.settle + 3'h1;
            end
            else
            begin
                st_d.seen_rst = 1'b1;
                st_d.enabled = sw.maint_enable_bit;
                st_d.state = sw.maint_enable_bit ? maint_seq_pkg::ST_IDLE
                    : maint_seq_pkg::ST_OFF;
            end
        end
        else
        begin
            if (!online_s && st_q.state != maint_seq_pkg::ST_OFF)
            begin
                st_d.state = maint_seq_pkg::ST_IDLE;
                st_d.cmd.halt = 1'b1;
            end
            else
            begin
                case (st_q.state)
                    maint_seq_pkg::ST_OFF:
                    begin
                        st_d.state = maint_seq_pkg::ST_OFF;
                    end
                    maint_seq_pkg::ST_IDLE:
                    begin
                        if (on_rise && go)
                        begin
                            st_d.cfg = sw;
                            st_d.cmd.op = sw.op_select;
                            st_d.cmd.start = 1'b1;
                            st_d.cmd.halt = 1'b0;
                            st_d.state = maint_seq_pkg::ST_RUN;
                        end
                    end
                    maint_seq_pkg::ST_RUN:
                    begin
                        if (err && !ignore_cfg && st_q.cfg.stop_on_error_bit)
                        begin
                            st_d.cmd.halt = 1'b1;
                            st_d.events[`EV_ERROR] = 1'b1;
                            st_d.state = maint_seq_pkg::ST_HALT;
                        end
                        else if (err && !ignore_cfg && st_q.cfg.retry_on_error_bit
                            && !no_retry_op)
                        begin
                            st_d.cmd.reposition = 1'b1;
                            st_d.cmd.start = 1'b1;
                            st_d.events[`EV_RETRY] = 1'b1;
                        end
                        else if (ev.op_done)
                        begin
                            st_d.events[`EV_DONE] = 1'b1;
                            if (st_q.cfg.single_step_bit && !ignore_cfg)
                            begin
                                st_d.state = maint_seq_pkg::ST_WAIT;
                            end
                            else
                            begin
                                st_d.cmd.start = 1'b1;
                            end
                        end
                    end
                    maint_seq_pkg::ST_WAIT:
                    begin
                        st_d.state = maint_seq_pkg::ST_WAIT;
                    end
                    maint_seq_pkg::ST_HALT:
                    begin
                        st_d.state = maint_seq_pkg::ST_HALT;
                    end
                    default: st_d.state = maint_seq_pkg::ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
        end
    end

    assign drive_cmd_o = st_q.cmd;
    assign maint_active_o = st_q.enabled;

    halt_on_error_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && st_q.state == maint_seq_pkg::ST_RUN && err && !ignore_cfg
        && st_q.cfg.stop_on_error_bit && online_s)
        |=> st_q.cmd.halt && st_q.state == maint_seq_pkg::ST_HALT)
        else $error("no halt on error");
    start_needs_online_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.cmd.start && $past(st_q.state) == maint_seq_pkg::ST_IDLE) |-> st_q.online)
        else $error("start while off-line");
    off_stays_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.seen_rst && !st_q.enabled) |=> st_q.state == maint_seq_pkg::ST_OFF)
        else $error("maintenance left off state");
    cfg_held_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == maint_seq_pkg::ST_RUN && $past(st_q.state) == maint_seq_pkg::ST_RUN)
        |-> $stable(st_q.cfg))
        else $error("selection changed during run");
    loop_restart_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && online_s && st_q.state == maint_seq_pkg::ST_RUN && ev.op_done && !err
        && !st_q.cfg.single_step_bit) |=> st_q.cmd.start)
        else $error("loop did not restart");
    step_wait_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (ce_i && online_s && st_q.state == maint_seq_pkg::ST_RUN && ev.op_done && !err
        && st_q.cfg.single_step_bit && !ignore_cfg)
        |=> st_q.state == maint_seq_pkg::ST_WAIT)
        else $error("single step did not wait");
    no_gap_retry_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.cmd.reposition) |-> !$past(no_retry_op) && $past(st_q.cfg.retry_on_error_bit))
        else $error("illegal retry");
    frpi_no_stop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_q.state == maint_seq_pkg::ST_HALT && $past(st_q.state) == maint_seq_pkg::ST_RUN)
        |-> $past(!ignore_cfg))
        else $error("flux test stopped on error");

    // named steps of a test run
    sequence idle_online_go_s;
        ce_i && st_q.state == maint_seq_pkg::ST_IDLE && on_rise && go;
    endsequence
    sequence run_entered_s;
        st_q.state == maint_seq_pkg::ST_RUN && st_q.cmd.start && !st_q.cmd.halt;
    endsequence
    sequence retry_taken_s;
        ce_i && online_s && st_q.state == maint_seq_pkg::ST_RUN && err && !ignore_cfg
            && !st_q.cfg.stop_on_error_bit && st_q.cfg.retry_on_error_bit && !no_retry_op;
    endsequence
    sequence retry_issued_s;
        st_q.cmd.reposition && st_q.cmd.start && st_q.state == maint_seq_pkg::ST_RUN;
    endsequence
    sequence offline_s;
        ce_i && st_q.seen_rst && !online_s && st_q.state != maint_seq_pkg::ST_OFF;
    endsequence
    sequence idle_halted_s;
        st_q.state == maint_seq_pkg::ST_IDLE && st_q.cmd.halt;
    endsequence

    run_start_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        idle_online_go_s
        |=> run_entered_s)
        else $error("test did not start on going on-line");

    op_latched_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        idle_online_go_s
        |=> st_q.cmd.op == $past(sw.op_select))
        else $error("test number not latched at on-line");

    retry_step_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        retry_taken_s
        |=> retry_issued_s)
        else $error("no retry after error");

    offline_idle_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        offline_s
        |=> idle_halted_s)
        else $error("off-line did not return to idle");

    no_stop_clear_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && online_s && st_q.state == maint_seq_pkg::ST_RUN && err && !st_q.cfg.stop_on_error_bit)
        |=> st_q.state != maint_seq_pkg::ST_HALT)
        else $error("stopped with stop-on-error clear");

    read_skips_single_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && online_s && st_q.state == maint_seq_pkg::ST_RUN && is_read
        && ev.single_track_error && !ev.multiple_track_error && !ev.runaway && !ev.op_done)
        |=> !st_q.cmd.reposition && st_q.state == maint_seq_pkg::ST_RUN)
        else $error("read acted on single-track error");

    no_retry_clear_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && online_s && st_q.state == maint_seq_pkg::ST_RUN && err
        && !st_q.cfg.retry_on_error_bit) |=> !st_q.cmd.reposition)
        else $error("retry with retry-on-error clear");

    wait_holds_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && online_s && st_q.state == maint_seq_pkg::ST_WAIT)
        |=> st_q.state == maint_seq_pkg::ST_WAIT && !st_q.cmd.start)
        else $error("single step left its wait");

    halt_holds_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && online_s && st_q.state == maint_seq_pkg::ST_HALT)
        |=> st_q.state == maint_seq_pkg::ST_HALT && st_q.cmd.halt && !st_q.cmd.start)
        else $error("halt released while on-line");

    runaway_stop_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && online_s && st_q.state == maint_seq_pkg::ST_RUN && ev.runaway
        && st_q.cfg.stop_on_error_bit && !ignore_cfg) |=> st_q.state == maint_seq_pkg::ST_HALT)
        else $error("no stop on runaway");

    flux_loops_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && online_s && st_q.state == maint_seq_pkg::ST_RUN && ignore_cfg && ev.op_done)
        |=> st_q.cmd.start && st_q.state == maint_seq_pkg::ST_RUN)
        else $error("flux test did not loop");

    enable_once_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        st_q.seen_rst
        |=> st_q.seen_rst && $stable(st_q.enabled))
        else $error("enable changed after power-up");

    go_gate_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (ce_i && st_q.state == maint_seq_pkg::ST_IDLE && on_rise && !go)
        |=> st_q.state == maint_seq_pkg::ST_IDLE)
        else $error("test started without go");

    select_binary_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        st_q.state == maint_seq_pkg::ST_RUN
        |-> st_q.cmd.op == st_q.cfg.op_select)
        else $error("operation differs from selection");
endmodule

// ---- logic/maint_seq_map.svh ----
// constants for the maintenance test sequencer
`ifndef MAINT_SEQ_MAP_SVH
`define MAINT_SEQ_MAP_SVH
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_IRQ_STAT 4'h8
`define ADDR_IRQ_CLR 4'hc
`define ADDR_IRQ_EN 5'h10
`define CTRL_GO_BIT 0
`define CTRL_RESET 32'h0000_0000
`define SYNC_SETTLE 3'h4
`define IRQ_EN_RESET 3'h0
`define EV_DONE 0
`define EV_ERROR 1
`define EV_RETRY 2
`define OP_FRPI 4'h1
`define OP_GAP 4'h7
`define OP_FSF 4'hb
`define OP_BSF 4'hc
`define OP_READ_A 4'h0
`define OP_READ_B 4'h8
`define OP_READ_R 4'he
`define OP_READ_REV 4'hf
`endif

// ---- logic/maint_seq_pkg.sv ----
// types for the maintenance test sequencer
package maint_seq_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_WAIT = 3'b011,
        ST_HALT = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic maint_enable_bit;
        logic stop_on_error_bit;
        logic retry_on_error_bit;
        logic single_step_bit;
        logic [3:0] op_select;
    } maintenance_config_switch_bank_t;

    typedef struct packed {
        logic single_track_error;
        logic multiple_track_error;
        logic runaway;
        logic op_done;
    } drive_status_t;

    typedef struct packed {
        logic start;
        logic reposition;
        logic halt;
        logic [3:0] op;
    } drive_cmd_t;
endpackage

// ---- logic/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } sync_state_t;
    sync_state_t st_q;
    sync_state_t st_d;
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i])
            begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
        end
    end
    assign sync_o = st_q.out;
endmodule

// ---- logic/wb_regs.sv ----
// wishbone classic slave holding control, status and interrupt registers
`include "maint_seq_map.svh"
`timescale 1ns/1ps
module wb_regs (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [7:0] status_i,
    input wire logic [2:0] events_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic go_o,
    output logic irq_o
);
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic go;
        logic [2:0] ist;
        logic [2:0] ien;
        logic irq;
    } regs_state_t;
    regs_state_t st_q;
    regs_state_t st_d;
    logic acc;
    logic [2:0] clr;
    always_comb
    begin
        st_d = st_q;
        acc = wb_cyc_i && wb_stb_i && !st_q.ack;
        clr = 3'h0;
        st_d.ack = acc;
        st_d.dat = 32'h0000_0000;
        if (acc && wb_we_i && wb_sel_i[0])
        begin
            case (wb_adr_i)
                5'(`ADDR_CTRL): st_d.go = wb_dat_i[`CTRL_GO_BIT];
                5'(`ADDR_IRQ_CLR): clr = wb_dat_i[2:0];
                `ADDR_IRQ_EN: st_d.ien = wb_dat_i[2:0];
                default: ;
            endcase
        end
        if (acc && !wb_we_i)
        begin
            case (wb_adr_i)
                5'(`ADDR_CTRL): st_d.dat = {31'h0, st_q.go};
                5'(`ADDR_STATUS): st_d.dat = {24'h0, status_i};
                5'(`ADDR_IRQ_STAT): st_d.dat = {29'h0, st_q.ist};
                `ADDR_IRQ_EN: st_d.dat = {29'h0, st_q.ien};
                default: st_d.dat = 32'h0000_0000;
            endcase
        end
        // set wins over clear
        st_d.ist = (st_q.ist & ~clr) | events_i;
        st_d.irq = |(st_d.ist & st_d.ien);
    end
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_q <= '0;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
        end
    end
    assign wb_ack_o = st_q.ack;
    assign wb_dat_o = st_q.dat;
    assign go_o = st_q.go;
    assign irq_o = st_q.irq;
endmodule

// ---- verif/tape_drive_model.sv ----
// behavioural tape drive answering the sequencer's commands
`timescale 1ns/1ps
module tape_drive_model (
    input wire logic core_clk_i,
    input wire logic [6:0] drive_cmd_i,
    input wire logic [2:0] err_i,
    input wire logic slow_i,
    output logic [3:0] drive_status_o
);
    maint_seq_pkg::drive_cmd_t cmd;
    int cnt_q = -1;
    assign cmd = drive_cmd_i;
    // error window, then completion window, six cycles each to pass the synchroniser
    assign drive_status_o = {(cnt_q > 6 && cnt_q < 13) ? err_i : 3'h0, cnt_q > 0 && cnt_q < 7};
    always @(posedge core_clk_i)
    begin
        if (cmd.start || cmd.reposition)
            cnt_q <= slow_i ? 52 : 16;
        else if (cmd.halt)
            cnt_q <= -1;
        else if (cnt_q >= 0)
            cnt_q <= cnt_q - 1;
    end
endmodule

// ---- verif/tape_maintenance_test_sequencer_test.sv ----
// self-checking bench for the maintenance test sequencer
`timescale 1ns/1ps
module tape_maintenance_test_sequencer_test;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [7:0] switch_bank_i = 8'h80;
    logic online_i = 1'b0;
    logic [2:0] err_q = 3'h0;
    logic slow_q = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o, maint_active_o;
    logic [3:0] drive_status;
    logic [6:0] drive_cmd_o;
    maint_seq_pkg::drive_cmd_t cmd;
    logic [63:0] exp_rd[$];
    logic [3:0] exp_op = 4'h0;
    int starts = 0, repos = 0, cycles = 0, failures = 0, tests_run = 0;
    logic [15:0] tbl [7] = '{16'hb542, 16'hb522, 16'hb040, 16'hb022, 16'hb720, 16'h9520, 16'hf120};
    assign cmd = drive_cmd_o;

    maint_test_sequencer uut (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(1'b1),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .switch_bank_i(switch_bank_i),
        .online_i(online_i),
        .drive_status_i(drive_status),
        .drive_cmd_o(drive_cmd_o),
        .maint_active_o(maint_active_o),
        .irq_o(irq_o)
    );

    tape_drive_model drive (
        .core_clk_i(core_clk_i),
        .drive_cmd_i(drive_cmd_o),
        .err_i(err_q),
        .slow_i(slow_q),
        .drive_status_o(drive_status)
    );

    initial
    begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // watcher: timeout, read data, start pulses and repositions
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            failures++;
            test_done;
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_rd.size() > 0)
        begin
            check(wb_dat_o & exp_rd[0][63:32], exp_rd[0][31:0]);
            void'(exp_rd.pop_front());
        end
        if (cmd.start === 1'b1)
        begin
            starts++;
            check({28'h0, cmd.op}, {28'h0, exp_op});
        end
        if (cmd.reposition === 1'b1)
        begin
            repos++;
            if (repos == 2)
                err_q <= 3'h0;
        end
    end

    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        @(posedge core_clk_i);
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge core_clk_i);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_rd.push_back({m, e});
        bus(a, 1'b0, 32'h0);
    endtask

    task automatic do_reset(input logic [7:0] sw);
        switch_bank_i <= sw;
        online_i <= 1'b0;
        rst_i <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // the enable switch is caught after the synchroniser fills
        repeat (7) @(posedge core_clk_i);
    endtask

    // off-line, new switches, back on-line, then let the test run
    task automatic go_on(input logic [7:0] sw, input logic [2:0] err);
        int n;
        online_i <= 1'b0;
        repeat (10) @(posedge core_clk_i);
        switch_bank_i <= sw;
        err_q <= err;
        exp_op = sw[3:0];
        starts = 0;
        repos = 0;
        repeat (10) @(posedge core_clk_i);
        online_i <= 1'b1;
        n = 0;
        while (starts == 0 && n < 100)
        begin
            @(posedge core_clk_i);
            n++;
        end
        switch_bank_i <= sw ^ {4'h0, 4'($urandom_range(15, 1))};
        repeat (200) @(posedge core_clk_i);
    endtask

    initial
    begin
        void'($urandom(32'hfcab));
        do_reset(8'h80);
        check({31'h0, maint_active_o}, 32'h1);
        rd(5'h00, 32'hffffffff, 32'h0);
        rd(5'h10, 32'hffffffff, 32'h0);
        bus(5'h14, 1'b1, 32'hffffffff);
        rd(5'h14, 32'hffffffff, 32'h0);
        bus(5'h00, 1'b1, 32'h1);
        bus(5'h10, 1'b1, 32'h7);
        rd(5'h10, 32'hffffffff, 32'h7);
        rd(5'h04, 32'hdd, 32'h85);
        for (int i = 0; i < 16; i++)
        begin
            slow_q <= i[0];
            go_on({4'h9, 4'(i)}, 3'h0);
            check(32'(starts != 0), 32'h1);
            check(32'(starts > 1), 32'(i == 1));
            if (i != 1)
                rd(5'h04, 32'h5c, 32'h4c);
        end
        check({31'h0, irq_o}, 32'h1);
        bus(5'h0c, 1'b1, 32'h7);
        repeat (2) @(posedge core_clk_i);
        check({31'h0, irq_o}, 32'h0);
        bus(5'h10, 1'b1, 32'h0);
        go_on(8'h86, 3'h0);
        check(32'(starts > 1), 32'h1);
        check({31'h0, irq_o}, 32'h0);
        bus(5'h10, 1'b1, 32'h7);
        repeat (2) @(posedge core_clk_i);
        check({31'h0, irq_o}, 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            go_on(8'hd5, 3'h4 >> k);
            check({31'h0, cmd.halt}, 32'h1);
            check(starts, 32'h1);
            rd(5'h04, 32'h1c, 32'h10);
            rd(5'h08, 32'h2, 32'h2);
        end
        bus(5'h0c, 1'b1, 32'h7);
        go_on(8'h95, 3'h2);
        check(starts, 32'h1);
        rd(5'h08, 32'h2, 32'h0);
        rd(5'h04, 32'h1c, 32'h0c);
        for (int t = 0; t < 7; t++)
        begin
            go_on(tbl[t][15:8], tbl[t][6:4]);
            check(repos, {30'h0, tbl[t][1:0]});
        end
        check(32'(starts > 1), 32'h1);
        check({31'h0, cmd.halt}, 32'h0);
        do_reset(8'h05);
        bus(5'h00, 1'b1, 32'h1);
        rd(5'h04, 32'h80, 32'h0);
        go_on(8'h85, 3'h0);
        check(starts, 32'h0);
        check({31'h0, maint_active_o}, 32'h0);
        check(exp_rd.size(), 32'h0);
        test_done;
    end
endmodule
